// ==== dps_pkg.sv ====
// Constants and types for the detector front-panel and sensor-status block.
// Assumes a 125 MHz system clock; all users reference names as dps_pkg::name.
package dps_pkg;

    localparam int CLK_MHZ        = 125;
    // Loop scan slot per enabled loop, piezo sample interval, lamp time base
    localparam int LOOP_SLOT_US   = 300;
    localparam int LOOP_SLOT_CYC  = LOOP_SLOT_US * CLK_MHZ;
    localparam int PIEZO_TICK_US  = 100;
    localparam int PIEZO_TICK_CYC = PIEZO_TICK_US * CLK_MHZ;
    localparam int MS_TICK_US     = 1000;
    localparam int MS_TICK_CYC    = MS_TICK_US * CLK_MHZ;
    localparam int HB_HALF_MS     = 500;
    localparam int BLINK_HALF_MS  = 250;
    localparam int STRETCH_MS     = 50;

    localparam int NLOOP   = 8;
    localparam int NPIEZO  = 8;
    localparam int NLANE   = 4;
    localparam int PZ_W    = 12;
    localparam int DELTA_W = 16;
    localparam int NSTR    = 14;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_OVR     = 8'h04;
    localparam logic [7:0] OFF_THR     = 8'h08;
    localparam logic [7:0] OFF_PTHR    = 8'h0c;
    localparam logic [7:0] OFF_LSTAT   = 8'h10;
    localparam logic [7:0] OFF_PHEALTH = 8'h14;

    // Field positions and reset values
    localparam int CTRL_RETUNE_BIT   = 3;
    localparam logic [2:0]  CFG_RST  = 3'h0;
    localparam logic [31:0] OVR_RST  = 32'h0000_0000;
    localparam logic [31:0] THR_RST  = 32'h0040_0080;
    localparam logic [15:0] PTHR_RST = 16'h0200;

    // Sensor configuration codes
    localparam logic [2:0] CFG_LL   = 3'h0;
    localparam logic [2:0] CFG_LPL  = 3'h1;
    localparam logic [2:0] CFG_LPPL = 3'h2;
    localparam logic [2:0] CFG_PP   = 3'h3;
    localparam logic [2:0] CFG_PLP  = 3'h4;

    // Piezo health grades
    localparam logic [1:0] HL_FAIL = 2'h0;
    localparam logic [1:0] HL_WEAK = 2'h1;
    localparam logic [1:0] HL_GOOD = 2'h2;

    typedef enum logic [2:0] {
        SC_IDLE  = 3'b001,
        SC_NEXT  = 3'b010,
        SC_DWELL = 3'b100
    } dps_scan_t;

endpackage

// ==== dps_top.sv ====
// Front-panel lamps, panel switches, loop scanner, piezo sampler and piezo health.
// Assumes loop front end, piezo ADC and message pulses are on SYS_CLK;
// panel switches and the retune button are asynchronous pins.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps

// How it works
// RULE1: Power lamp lit while powered.
// RULE2: Heartbeat lamp flashes once per second.
// RULE3: Receive lamp flashes per supervisor message.
// RULE4: Transmit lamp flashes per message sent.
// RULE5: Retune button retunes all eight loops.
// RULE6: Enable switches, console override wins.
// RULE7: Sensitivity switches pick 10 or 8.
// RULE8: Lamp mapping follows sensor configuration.
// RULE9: Loop lamp: detect on, fault flashes.
// RULE10: Piezo lamp flashes on each detection.
// RULE11: Lane lamp flashes per valid vehicle.
// RULE12: Scan loops singly, threshold per sensitivity.
// RULE13: Scan period scales with enabled loops.
// RULE14: Open and short faults readable.
// RULE15: Sample piezos every 100 us together.
// RULE16: Piezo health steps among G, W, F.
// RULE17: Flashes stretched; one common fault blink.
module dps_top #(
    parameter int LOOP_SLOT_CYC  = dps_pkg::LOOP_SLOT_CYC,
    parameter int PIEZO_TICK_CYC = dps_pkg::PIEZO_TICK_CYC,
    parameter int MS_TICK_CYC    = dps_pkg::MS_TICK_CYC
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        RETUNE_BTN,
    input  wire logic [7:0]  ENABLE_SW,
    input  wire logic [7:0]  SENS_SW,
    input  wire logic [15:0] LOOP_DELTA,
    input  wire logic        LOOP_OPEN,
    input  wire logic        LOOP_SHORT,
    input  wire logic [95:0] PIEZO_RESP,
    input  wire logic        MSG_RX,
    input  wire logic        MSG_TX,
    input  wire logic [3:0]  VEH_VALID,
    output logic [2:0]       LOOP_SEL,
    output logic             LOOP_RETUNE,
    output logic             POWER_INDICATOR,
    output logic             HEARTBEAT_INDICATOR,
    output logic             RX_LAMP,
    output logic             TX_LAMP,
    output logic [7:0]       SENSOR_CHANNEL_LAMPS,
    output logic [3:0]       LANE_LAMPS
);

    typedef struct packed {
        logic [7:0]        en_s1;
        logic [7:0]        en_s2;
        logic [7:0]        sens_s1;
        logic [7:0]        sens_s2;
        logic              btn_s1;
        logic              btn_s2;
        logic              btn_d;
        logic [2:0]        cfg;
        logic [31:0]       ovr;
        logic [31:0]       thr;
        logic [15:0]       pthr;
        logic [31:0]       prdata;
        logic              pslverr;
        logic [23:0]       ms_cnt;
        logic              ms_tick;
        logic [9:0]        hb_cnt;
        logic [9:0]        bl_cnt;
        logic              hb;
        logic              blink;
        logic              pwr;
        logic [23:0]       pz_cnt;
        logic [7:0]        pz_above;
        dps_pkg::dps_scan_t st;
        logic [2:0]        sel;
        logic [23:0]       slot_cnt;
        logic [7:0]        det;
        logic [7:0]        opn;
        logic [7:0]        sht;
        logic [13:0][5:0]  str;
        logic [7:0]        act;
        logic [7:0][1:0]   hlth;
        logic              retune;
        logic [7:0]        lamp_ch;
        logic [3:0]        lamp_ln;
    } dps_state_t;

    localparam dps_state_t RST_VAL = '{
        cfg: dps_pkg::CFG_RST, ovr: dps_pkg::OVR_RST, thr: dps_pkg::THR_RST,
        pthr: dps_pkg::PTHR_RST, st: dps_pkg::SC_IDLE, default: '0};

    dps_state_t s_q;
    dps_state_t s_d;

    logic [7:0]  en_eff;
    logic [7:0]  sens_eff;
    logic [7:0]  pz_hit;
    logic [13:0] trig;
    logic [2:0]  nxt;
    logic        nxt_ok;
    logic        wr;
    logic [15:0] thr_sel;
    logic [7:0]  loop_lamp;
    logic [7:0]  pz_lamp;

    always_comb begin
        s_d = s_q;
        // RULE6: console override per loop
        en_eff   = (s_q.en_s2 & ~s_q.ovr[15:8]) | (s_q.ovr[7:0] & s_q.ovr[15:8]);
        // RULE7: right means level 10, else 8
        sens_eff = (s_q.sens_s2 & ~s_q.ovr[31:24]) | (s_q.ovr[23:16] & s_q.ovr[31:24]);

        // Synchronisers: first stage feeds only the second
        s_d.en_s1   = ENABLE_SW;
        s_d.en_s2   = s_q.en_s1;
        s_d.sens_s1 = SENS_SW;
        s_d.sens_s2 = s_q.sens_s1;
        s_d.btn_s1  = RETUNE_BTN;
        s_d.btn_s2  = s_q.btn_s1;
        s_d.btn_d   = s_q.btn_s2;

        // RULE1: dark while reset is held, lit from the first edge after reset is released
        s_d.pwr = 1'b1;

        // Millisecond time base keeps the lamp counters narrow
        s_d.ms_tick = 1'b0;
        s_d.ms_cnt  = s_q.ms_cnt + 24'h1;
        if (s_q.ms_cnt == 24'(MS_TICK_CYC - 1)) begin
            s_d.ms_cnt  = '0;
            s_d.ms_tick = 1'b1;
        end
        if (s_q.ms_tick) begin
            // RULE2: toggle every half second
            s_d.hb_cnt = s_q.hb_cnt + 10'h1;
            if (s_q.hb_cnt == 10'(dps_pkg::HB_HALF_MS - 1)) begin
                s_d.hb_cnt = '0;
                s_d.hb     = ~s_q.hb;
            end
            // RULE17: one blink shared by all faults
            s_d.bl_cnt = s_q.bl_cnt + 10'h1;
            if (s_q.bl_cnt == 10'(dps_pkg::BLINK_HALF_MS - 1)) begin
                s_d.bl_cnt = '0;
                s_d.blink  = ~s_q.blink;
            end
        end

        // APB: zero wait states; read data and error latched in setup
        wr        = PSEL & PENABLE & PWRITE;
        s_d.retune = 1'b0;
        if (PSEL & ~PENABLE) begin
            s_d.pslverr = 1'b0;
            s_d.prdata  = '0;
            case (PADDR)
                dps_pkg::OFF_CTRL:    s_d.prdata = {29'h0, s_q.cfg};
                dps_pkg::OFF_OVR:     s_d.prdata = s_q.ovr;
                dps_pkg::OFF_THR:     s_d.prdata = s_q.thr;
                dps_pkg::OFF_PTHR:    s_d.prdata = {16'h0, s_q.pthr};
                // RULE14: fault state readable
                dps_pkg::OFF_LSTAT:   s_d.prdata = {en_eff, s_q.sht, s_q.opn, s_q.det};
                dps_pkg::OFF_PHEALTH: s_d.prdata = {16'h0, s_q.hlth};
                default:              s_d.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            case (PADDR)
                dps_pkg::OFF_CTRL: begin
                    s_d.cfg    = PWDATA[2:0];
                    s_d.retune = PWDATA[dps_pkg::CTRL_RETUNE_BIT];
                end
                dps_pkg::OFF_OVR:  s_d.ovr  = PWDATA;
                dps_pkg::OFF_THR:  s_d.thr  = PWDATA;
                dps_pkg::OFF_PTHR: s_d.pthr = PWDATA[15:0];
                default: ;
            endcase
        end
        // RULE5: button press retunes every loop
        if (s_q.btn_s2 & ~s_q.btn_d) begin
            s_d.retune = 1'b1;
        end
        if (s_q.retune) begin
            s_d.det = '0;
        end

        // RULE13: next enabled loop; disabled loops take no slot
        nxt    = s_q.sel;
        nxt_ok = 1'b0;
        for (int k = 1; k <= dps_pkg::NLOOP; k++) begin
            if (!nxt_ok && en_eff[3'(s_q.sel + 3'(k))]) begin
                nxt    = 3'(s_q.sel + 3'(k));
                nxt_ok = 1'b1;
            end
        end
        // RULE12: threshold from the loop's sensitivity
        thr_sel = sens_eff[s_q.sel] ? s_q.thr[31:16] : s_q.thr[15:0];
        s_d.det = s_d.det & en_eff;
        s_d.opn = s_q.opn & en_eff;
        s_d.sht = s_q.sht & en_eff;
        case (s_q.st)
            dps_pkg::SC_IDLE: begin
                if (nxt_ok) begin
                    s_d.st = dps_pkg::SC_NEXT;
                end
            end
            dps_pkg::SC_NEXT: begin
                s_d.slot_cnt = '0;
                s_d.sel      = nxt;
                s_d.st       = nxt_ok ? dps_pkg::SC_DWELL : dps_pkg::SC_IDLE;
            end
            dps_pkg::SC_DWELL: begin
                s_d.slot_cnt = s_q.slot_cnt + 24'h1;
                if (s_q.slot_cnt == 24'(LOOP_SLOT_CYC - 1)) begin
                    // RULE12: one loop measured at a time
                    if (en_eff[s_q.sel] && !s_q.retune) begin
                        s_d.det[s_q.sel] = ~LOOP_OPEN & ~LOOP_SHORT & (LOOP_DELTA > thr_sel);
                        // RULE14: latch fault per loop
                        s_d.opn[s_q.sel] = LOOP_OPEN;
                        s_d.sht[s_q.sel] = LOOP_SHORT;
                    end
                    s_d.st = dps_pkg::SC_NEXT;
                end
            end
            default: s_d.st = dps_pkg::SC_IDLE;
        endcase

        // RULE15: all eight piezos compared on the same tick
        pz_hit     = '0;
        s_d.pz_cnt = s_q.pz_cnt + 24'h1;
        if (s_q.pz_cnt == 24'(PIEZO_TICK_CYC - 1)) begin
            s_d.pz_cnt = '0;
            for (int i = 0; i < dps_pkg::NPIEZO; i++) begin
                s_d.pz_above[i] = PIEZO_RESP[i*dps_pkg::PZ_W +: dps_pkg::PZ_W] > s_q.pthr[11:0];
                pz_hit[i]       = s_d.pz_above[i] & ~s_q.pz_above[i];
            end
        end

        // RULE16: grade on each lane vehicle; new activity beats the clear
        for (int i = 0; i < dps_pkg::NPIEZO; i++) begin
            if (VEH_VALID[i/2]) begin
                if (s_q.act[i] | pz_hit[i]) begin
                    if (s_q.hlth[i] != dps_pkg::HL_GOOD) begin
                        s_d.hlth[i] = s_q.hlth[i] + 2'h1;
                    end
                end else if (s_q.hlth[i] != dps_pkg::HL_FAIL) begin
                    s_d.hlth[i] = s_q.hlth[i] - 2'h1;
                end
                s_d.act[i] = pz_hit[i];
            end else begin
                s_d.act[i] = s_q.act[i] | pz_hit[i];
            end
        end

        // RULE17: stretch each event to a visible flash
        trig = {VEH_VALID, pz_hit, MSG_TX, MSG_RX};
        for (int j = 0; j < dps_pkg::NSTR; j++) begin
            if (trig[j]) begin
                s_d.str[j] = 6'(dps_pkg::STRETCH_MS);
            end else if (s_q.ms_tick && s_q.str[j] != 6'h0) begin
                s_d.str[j] = s_q.str[j] - 6'h1;
            end
        end

        // RULE9: detect steady, fault blinks
        for (int i = 0; i < dps_pkg::NLOOP; i++) begin
            loop_lamp[i] = (s_q.opn[i] | s_q.sht[i]) ? s_q.blink : s_q.det[i];
            // RULE10: piezo lamp only while stretched
            pz_lamp[i]   = s_q.str[2 + i] != 6'h0;
        end
        // RULE8: channel and lane lamp selection
        case (s_q.cfg)
            dps_pkg::CFG_PP, dps_pkg::CFG_PLP: s_d.lamp_ch = pz_lamp;
            default:                           s_d.lamp_ch = loop_lamp;
        endcase
        for (int l = 0; l < dps_pkg::NLANE; l++) begin
            case (s_q.cfg)
                dps_pkg::CFG_LPL, dps_pkg::CFG_LPPL: s_d.lamp_ln[l] = pz_lamp[2*l];
                dps_pkg::CFG_PLP:                    s_d.lamp_ln[l] = loop_lamp[2*l];
                // RULE11: valid vehicle flash
                default:                             s_d.lamp_ln[l] = s_q.str[10 + l] != 6'h0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            s_q <= RST_VAL;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA               = s_q.prdata;
    assign PSLVERR              = s_q.pslverr;
    assign PREADY               = 1'b1;
    assign LOOP_SEL             = s_q.sel;
    assign LOOP_RETUNE          = s_q.retune;
    assign POWER_INDICATOR      = s_q.pwr;
    assign HEARTBEAT_INDICATOR  = s_q.hb;
    // RULE3: receive flash
    assign RX_LAMP              = s_q.str[0] != 6'h0;
    // RULE4: transmit flash
    assign TX_LAMP              = s_q.str[1] != 6'h0;
    assign SENSOR_CHANNEL_LAMPS = s_q.lamp_ch;
    assign LANE_LAMPS           = s_q.lamp_ln;

endmodule

// ==== dps_assertions.sv ====
// Port checks for dps_top: lamps, retune, loop slot, APB refusal.
// Assumes a bind to dps_top with the same tick parameters.
`timescale 1ns/1ps
module dps_assertions #(
    parameter int LOOP_SLOT_CYC = 20,
    parameter int MS_TICK_CYC   = 4
) (
    input wire logic       SYS_CLK,
    input wire logic       RST,
    input wire logic       PSEL,
    input wire logic       PENABLE,
    input wire logic [7:0] PADDR,
    input wire logic       PSLVERR,
    input wire logic       RETUNE_BTN,
    input wire logic       MSG_RX,
    input wire logic       MSG_TX,
    input wire logic [2:0] LOOP_SEL,
    input wire logic       LOOP_RETUNE,
    input wire logic       POWER_INDICATOR,
    input wire logic       HEARTBEAT_INDICATOR,
    input wire logic       RX_LAMP,
    input wire logic       TX_LAMP
);
    localparam int HB_PER = 500 * MS_TICK_CYC;
    int   sel_cnt_q;
    int   hb_cnt_q;
    logic sel_seen_q;
    logic hb_seen_q;

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    // First change after reset starts at an unknown phase, so it only arms the count
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sel_cnt_q  <= 0;
            hb_cnt_q   <= 0;
            sel_seen_q <= 1'b0;
            hb_seen_q  <= 1'b0;
        end else begin
            sel_cnt_q  <= $changed(LOOP_SEL) ? 0 : sel_cnt_q + 1;
            hb_cnt_q   <= $changed(HEARTBEAT_INDICATOR) ? 0 : hb_cnt_q + 1;
            sel_seen_q <= sel_seen_q | $changed(LOOP_SEL);
            hb_seen_q  <= hb_seen_q | $changed(HEARTBEAT_INDICATOR);
        end
    end

    chk_power_lit: assert property (!$past(RST) |-> POWER_INDICATOR)
        else $error("power lamp dark");
    chk_hb_period: assert property ($changed(HEARTBEAT_INDICATOR) && hb_seen_q |-> hb_cnt_q == HB_PER - 1)
        else $error("heartbeat period wrong");
    chk_rx_flash: assert property (MSG_RX |-> ##[1:2] RX_LAMP)
        else $error("rx lamp missing");
    chk_tx_flash: assert property (MSG_TX |-> ##[1:2] TX_LAMP)
        else $error("tx lamp missing");
    chk_retune_start: assert property ($rose(RETUNE_BTN) |-> ##[1:5] LOOP_RETUNE)
        else $error("button gave no retune");
    chk_retune_pulse: assert property (LOOP_RETUNE |=> !LOOP_RETUNE)
        else $error("retune pulse too long");
    chk_scan_slot: assert property ($changed(LOOP_SEL) && sel_seen_q |-> sel_cnt_q == LOOP_SLOT_CYC)
        else $error("loop slot length wrong");
    chk_bad_addr: assert property (PSEL && PENABLE && PADDR > 8'h14 |-> PSLVERR)
        else $error("unmapped access accepted");
endmodule

// ==== dps_sensor_model.sv ====
// Road sensors: the scanned loop and all eight piezos answer.
// Assumes the bench says which loops see a car or fault, which piezos an axle.
`timescale 1ns/1ps
module dps_sensor_model (
    input  wire logic [2:0]  loop_sel,
    input  wire logic [7:0]  veh_on,
    input  wire logic [7:0]  open_on,
    input  wire logic [7:0]  short_on,
    input  wire logic [7:0]  axle_on,
    output logic      [15:0] loop_delta,
    output logic             loop_open,
    output logic             loop_short,
    output logic      [95:0] piezo_resp
);
    // scanned loop answers
    // Car shift lies between the two reset thresholds, so only sensitivity 10 trips
    assign loop_delta = veh_on[loop_sel] ? 16'h0060 : 16'h0000;
    assign loop_open  = open_on[loop_sel];
    assign loop_short = short_on[loop_sel];
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            piezo_resp[12*i +: 12] = axle_on[i] ? 12'h300 : 12'h010;
        end
    end
endmodule

// ==== test_dps_top.sv ====
// Bench for dps_top: APB register checks, switches, loops, piezos, lamps.
// Assumes short tick parameters so lamp and scan times stay small.
`timescale 1ns/1ps
module test_dps_top;
    logic        SYS_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, err;
    logic        RETUNE_BTN = 1'b0, MSG_RX = 1'b0, MSG_TX = 1'b0, PREADY, PSLVERR, LOOP_OPEN, LOOP_SHORT;
    logic        LOOP_RETUNE, POWER_INDICATOR, HEARTBEAT_INDICATOR, RX_LAMP, TX_LAMP;
    logic [7:0]  PADDR = 8'h00, ENABLE_SW = 8'hff, SENS_SW = 8'h55, SENSOR_CHANNEL_LAMPS;
    logic [7:0]  open_on = 8'h00, short_on = 8'h00, axle_on = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [15:0] LOOP_DELTA;
    logic [95:0] PIEZO_RESP;
    logic [3:0]  VEH_VALID = 4'h0, LANE_LAMPS;
    logic [2:0]  LOOP_SEL;
    int          mismatches = 0, tests_run = 0, retunes = 0, hb_flips = 0, hi [3];

    always #4 SYS_CLK = ~SYS_CLK;
    always @(negedge SYS_CLK) retunes += (LOOP_RETUNE === 1'b1);
    // Count only real toggles: the X to 0 step at the first reset edge is no heartbeat
    always @(HEARTBEAT_INDICATOR) if (!RST) hb_flips++;

    dps_top #(.LOOP_SLOT_CYC(20), .PIEZO_TICK_CYC(10), .MS_TICK_CYC(4)) i_dut (
        .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RETUNE_BTN(RETUNE_BTN),
        .ENABLE_SW(ENABLE_SW), .SENS_SW(SENS_SW), .LOOP_DELTA(LOOP_DELTA), .LOOP_OPEN(LOOP_OPEN),
        .LOOP_SHORT(LOOP_SHORT), .PIEZO_RESP(PIEZO_RESP), .MSG_RX(MSG_RX), .MSG_TX(MSG_TX),
        .VEH_VALID(VEH_VALID), .LOOP_SEL(LOOP_SEL), .LOOP_RETUNE(LOOP_RETUNE),
        .POWER_INDICATOR(POWER_INDICATOR), .HEARTBEAT_INDICATOR(HEARTBEAT_INDICATOR), .RX_LAMP(RX_LAMP),
        .TX_LAMP(TX_LAMP), .SENSOR_CHANNEL_LAMPS(SENSOR_CHANNEL_LAMPS), .LANE_LAMPS(LANE_LAMPS));

    dps_sensor_model i_road (.loop_sel(LOOP_SEL), .veh_on(8'hff), .open_on(open_on), .short_on(short_on),
        .axle_on(axle_on), .loop_delta(LOOP_DELTA), .loop_open(LOOP_OPEN), .loop_short(LOOP_SHORT),
        .piezo_resp(PIEZO_RESP));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Compares %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        cyc(1);
        PENABLE <= 1'b1;
        do begin
            cyc(1);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            print_verdict();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        cyc(1);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
        check(err, exp_err);
    endtask

    task automatic axle_round(input logic [7:0] ax, input logic [3:0] ln, input logic [31:0] hl);
        axle_on <= ax;
        cyc(15);
        VEH_VALID <= ln;
        cyc(1);
        VEH_VALID <= 4'h0;
        axle_on <= 8'h00;
        cyc(12);
        rchk(8'h14, hl, 1'b0);
    endtask

    initial begin
        cyc(5);
        RST <= 1'b0;
        cyc(2);
        check(POWER_INDICATOR, 1'b1);
        rchk(8'h00, 32'h0, 1'b0);
        rchk(8'h04, 32'h0, 1'b0);
        rchk(8'h08, 32'h0040_0080, 1'b0);
        rchk(8'h0c, 32'h0000_0200, 1'b0);
        rchk(8'h18, 32'h0, 1'b1);
        apb(1'b1, 8'h10, 32'hffff_ffff);
        cyc(400);
        rchk(8'h10, 32'hff00_0055, 1'b0);
        for (int c = 0; c < 5; c++) begin
            apb(1'b1, 8'h00, 32'(c));
            cyc(3);
            check(SENSOR_CHANNEL_LAMPS, c < 3 ? 8'h55 : 8'h00);
            check(LANE_LAMPS, c == 4 ? 4'hf : 4'h0);
        end
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'hffaa_f00f);
        cyc(400);
        rchk(8'h10, 32'h0f00_000a, 1'b0);
        apb(1'b1, 8'h04, 32'h0);
        ENABLE_SW <= 8'h03;
        cyc(100);
        for (int i = 0; i < 40; i++) begin
            cyc(1);
            check(LOOP_SEL[2:1], 2'h0);
        end
        rchk(8'h10, 32'h0300_0001, 1'b0);
        $display("Test switches done");
        ENABLE_SW <= 8'hff;
        open_on <= 8'h02;
        short_on <= 8'h04;
        cyc(400);
        rchk(8'h10, 32'hff04_0251, 1'b0);
        hi = '{0, 0, 0};
        repeat (2000) begin
            cyc(1);
            for (int b = 0; b < 3; b++) hi[b] += SENSOR_CHANNEL_LAMPS[b];
        end
        check(hi[0], 2000);
        check(hi[1], 1000);
        check(hi[2], 1000);
        open_on <= 8'h00;
        short_on <= 8'h00;
        retunes = 0;
        RETUNE_BTN <= 1'b1;
        cyc(10);
        RETUNE_BTN <= 1'b0;
        check(retunes, 1);
        apb(1'b1, 8'h00, 32'h8);
        cyc(4);
        check(retunes, 2);
        rchk(8'h00, 32'h0, 1'b0);
        $display("Test loops done");
        MSG_RX <= 1'b1;
        cyc(1);
        MSG_RX <= 1'b0;
        cyc(3);
        check({RX_LAMP, TX_LAMP}, 2'b10);
        cyc(97);
        MSG_TX <= 1'b1;
        cyc(1);
        MSG_TX <= 1'b0;
        cyc(3);
        check({RX_LAMP, TX_LAMP}, 2'b11);
        cyc(110);
        check({RX_LAMP, TX_LAMP}, 2'b01);
        cyc(100);
        check({RX_LAMP, TX_LAMP}, 2'b00);
        apb(1'b1, 8'h00, 32'h3);
        axle_round(8'h81, 4'h9, 32'h0000_4001);
        check(SENSOR_CHANNEL_LAMPS, 8'h81);
        check(LANE_LAMPS, 4'h9);
        axle_round(8'h01, 4'h9, 32'h0000_0002);
        axle_round(8'h00, 4'h1, 32'h0000_0001);
        cyc(500);
        check({SENSOR_CHANNEL_LAMPS, LANE_LAMPS}, 12'h000);
        check(hb_flips, 2);
        $display("Test piezo done");
        print_verdict();
    end
endmodule

bind dps_top dps_assertions #(.LOOP_SLOT_CYC(LOOP_SLOT_CYC), .MS_TICK_CYC(MS_TICK_CYC)) i_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PSLVERR(PSLVERR),
    .RETUNE_BTN(RETUNE_BTN), .MSG_RX(MSG_RX), .MSG_TX(MSG_TX), .LOOP_SEL(LOOP_SEL),
    .LOOP_RETUNE(LOOP_RETUNE), .POWER_INDICATOR(POWER_INDICATOR), .HEARTBEAT_INDICATOR(HEARTBEAT_INDICATOR),
    .RX_LAMP(RX_LAMP), .TX_LAMP(TX_LAMP));
